// *** verilog/command_source_selector.v ***
// command source selector: chooses frequency and run command sources for the drive
//
// Overview of operation
// - serial setting 0,2,6 local; 1,3,7 port 1; 4,5,8 port 2 frequency.
// - serial setting 0,1,4 local; 2,3,5 port 1; 6,7,8 port 2 run.
// - fieldbus setting 1 frequency, 2 run, 3 both from fieldbus; 0 follows serial.
// - with link enable assigned, settings apply only while it is asserted.
// - with no link enable assignment, settings always apply.
// - routed run group holds forward, reverse and general digital inputs.
// - only the selected run source drives run outputs, never two at once.
// - port 1 is the keypad connector link, port 2 the terminal pair link.
// - local frequency from setting codes or multistep; local run from chosen run code.
`timescale 1ns/100ps
`default_nettype none
`include "cmd_source_consts.vh"
module command_source_selector #(
  parameter FREQ_W = 16,
  parameter GEN_W  = 7
) (
  input  wire              clk_in,
  input  wire              resetn_in,
  // AXI4-Lite slave
  input  wire [7:0]        s_axi_awaddr_in,
  input  wire              s_axi_awvalid_in,
  output wire              s_axi_awready_out,
  input  wire [31:0]       s_axi_wdata_in,
  input  wire [3:0]        s_axi_wstrb_in,
  input  wire              s_axi_wvalid_in,
  output wire              s_axi_wready_out,
  output reg  [1:0]        s_axi_bresp_out,
  output reg               s_axi_bvalid_out,
  input  wire              s_axi_bready_in,
  input  wire [7:0]        s_axi_araddr_in,
  input  wire              s_axi_arvalid_in,
  output wire              s_axi_arready_out,
  output reg  [31:0]       s_axi_rdata_out,
  output reg  [1:0]        s_axi_rresp_out,
  output reg               s_axi_rvalid_out,
  input  wire              s_axi_rready_in,
  // pins
  input  wire              link_enable_cmd_in,
  input  wire              forward_run_input_in,
  input  wire              reverse_run_input_in,
  input  wire [GEN_W-1:0]  general_input_in,
  input  wire              keypad_run_fwd_in,
  input  wire              keypad_run_rev_in,
  // serial port 1 (keypad connector) and port 2 (terminal pair) decoded images
  input  wire [FREQ_W-1:0] port1_freq_in,
  input  wire [GEN_W+1:0]  port1_run_in,
  input  wire [FREQ_W-1:0] port2_freq_in,
  input  wire [GEN_W+1:0]  port2_run_in,
  input  wire [FREQ_W-1:0] bus_freq_in,
  input  wire [GEN_W+1:0]  bus_run_in,
  input  wire [FREQ_W-1:0] multistep_freq_in,
  input  wire              multistep_active_in,
  // selected commands
  output reg  [FREQ_W-1:0] freq_cmd_out,
  output reg               run_fwd_out,
  output reg               run_rev_out,
  output reg  [GEN_W-1:0]  general_cmd_out,
  output reg  [1:0]        freq_source_out,
  output reg  [1:0]        run_source_out
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg  [GEN_W+3:0] pin_meta_reg;
reg  [GEN_W+3:0] pin_sync_reg;
wire [GEN_W+3:0] pin_raw = {link_enable_cmd_in, forward_run_input_in, reverse_run_input_in,
                            keypad_run_fwd_in, general_input_in};
wire             le_s  = pin_sync_reg[GEN_W+3];
wire             fwd_s = pin_sync_reg[GEN_W+2];
wire             rev_s = pin_sync_reg[GEN_W+1];
wire             kfwd_s = pin_sync_reg[GEN_W];
wire [GEN_W-1:0] gen_s = pin_sync_reg[GEN_W-1:0];
reg  [1:0]       krev_reg;

always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    pin_meta_reg <= {(GEN_W+4){1'b0}};
    pin_sync_reg <= {(GEN_W+4){1'b0}};
    krev_reg     <= 2'h0;
  end else begin
    pin_meta_reg <= pin_raw;
    pin_sync_reg <= pin_meta_reg;
    krev_reg     <= {krev_reg[0], keypad_run_rev_in};
  end
end

////////////////////////////////////////////////////////////////////////////////
// registers
reg [3:0]        serial_source_select_reg;
reg [1:0]        fieldbus_source_select_reg;
reg              le_assigned_reg;
reg              run_source_code_reg;   // 0 keypad, 1 terminals
reg              freq_code_sel_reg;     // 0 primary setting code, 1 alternate
reg [FREQ_W-1:0] freq_setting_code_reg;
reg [FREQ_W-1:0] alt_freq_setting_code_reg;
// link enable counts as on whenever no terminal is assigned to it
wire             effective_le = le_assigned_reg ? le_s : 1'b1;

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave; address and data may arrive in either order, one outstanding write and read
reg              aw_held_reg;
reg  [7:0]       aw_addr_reg;
reg              w_held_reg;
reg  [31:0]      w_data_reg;
reg  [3:0]       w_strb_reg;
// whichever channel comes first is parked until its partner has been taken
wire             aw_take = s_axi_awvalid_in && s_axi_awready_out;
wire             w_take  = s_axi_wvalid_in && s_axi_wready_out;
wire [7:0]       wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr_in;
wire [31:0]      wr_data = w_held_reg ? w_data_reg : s_axi_wdata_in;
wire [3:0]       wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb_in;
wire             wr_go   = (aw_held_reg || aw_take) && (w_held_reg || w_take);
wire             rd_go   = s_axi_arvalid_in && !s_axi_rvalid_out;
assign s_axi_awready_out = !aw_held_reg && !s_axi_bvalid_out;
assign s_axi_wready_out  = !w_held_reg && !s_axi_bvalid_out;
assign s_axi_arready_out = rd_go;

function [31:0] merge;
  input [31:0] old;
  input [31:0] nw;
  input [3:0]  strb;
  integer i;
  begin
    merge = old;
    for (i = 0; i < 4; i = i + 1)
      if (strb[i])
        merge[i*8 +: 8] = nw[i*8 +: 8];
  end
endfunction

// only these three words take writes; the rest answer with an error
function wr_mapped;
  input [7:0] addr;
  begin
    wr_mapped = (addr == `ADDR_CTRL) || (addr == `ADDR_FREQ_LOCAL) || (addr == `ADDR_FREQ_SEL);
  end
endfunction

wire [31:0] ctrl_word = {23'h0, le_assigned_reg, freq_code_sel_reg, run_source_code_reg,
                         fieldbus_source_select_reg, serial_source_select_reg};
wire [31:0] ctrl_new  = merge(ctrl_word, wr_data, wr_strb);
wire [31:0] f1_new    = merge({{(32-FREQ_W){1'b0}}, freq_setting_code_reg}, wr_data, wr_strb);
wire [31:0] f2_new    = merge({{(32-FREQ_W){1'b0}}, alt_freq_setting_code_reg}, wr_data, wr_strb);
wire        wr_bad    = !wr_mapped(wr_addr);

always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    serial_source_select_reg   <= 4'h0;
    fieldbus_source_select_reg <= 2'h0;
    le_assigned_reg            <= 1'b0;
    run_source_code_reg        <= 1'b0;
    freq_code_sel_reg          <= 1'b0;
    freq_setting_code_reg      <= {FREQ_W{1'b0}};
    alt_freq_setting_code_reg  <= {FREQ_W{1'b0}};
    s_axi_bvalid_out           <= 1'b0;
    s_axi_bresp_out            <= `RESP_OKAY;
    aw_held_reg                <= 1'b0;
    aw_addr_reg                <= 8'h00;
    w_held_reg                 <= 1'b0;
    w_data_reg                 <= 32'h0000_0000;
    w_strb_reg                 <= 4'h0;
  end else begin
    if (wr_go) begin
      aw_held_reg      <= 1'b0;
      w_held_reg       <= 1'b0;
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
      if (wr_addr == `ADDR_CTRL) begin
        // out-of-range serial codes are refused and the old one kept
        if (ctrl_new[`CTRL_SERIAL_LSB +: 4] <= `SERIAL_MAX)
          serial_source_select_reg <= ctrl_new[`CTRL_SERIAL_LSB +: 4];
        fieldbus_source_select_reg <= ctrl_new[`CTRL_FIELDBUS_LSB +: 2];
        run_source_code_reg        <= ctrl_new[`CTRL_RUN_CODE_BIT];
        freq_code_sel_reg          <= ctrl_new[`CTRL_ALT_FREQ_BIT];
        le_assigned_reg            <= ctrl_new[`CTRL_LE_ASSIGNED];
      end
      if (wr_addr == `ADDR_FREQ_LOCAL)
        freq_setting_code_reg <= f1_new[FREQ_W-1:0];
      if (wr_addr == `ADDR_FREQ_SEL)
        alt_freq_setting_code_reg <= f2_new[FREQ_W-1:0];
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end
end

always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    s_axi_rvalid_out <= 1'b0;
    s_axi_rdata_out  <= 32'h0000_0000;
    s_axi_rresp_out  <= `RESP_OKAY;
  end else begin
    if (rd_go) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= `RESP_OKAY;
      case (s_axi_araddr_in)
        `ADDR_CTRL:       s_axi_rdata_out <= ctrl_word;
        `ADDR_STATUS:     s_axi_rdata_out <= {26'h0, le_s, effective_le, run_source_out, freq_source_out};
        `ADDR_FREQ_LOCAL: s_axi_rdata_out <= {{(32-FREQ_W){1'b0}}, freq_setting_code_reg};
        `ADDR_FREQ_SEL:   s_axi_rdata_out <= {{(32-FREQ_W){1'b0}}, alt_freq_setting_code_reg};
        `ADDR_FREQ_PORT1: s_axi_rdata_out <= {{(32-FREQ_W){1'b0}}, freq_cmd_out};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// source decode

function [1:0] freq_src_of;
  input [3:0] code;
  begin
    case (code)
      4'h1, 4'h3, 4'h7: freq_src_of = `SRC_PORT1;
      4'h4, 4'h5, 4'h8: freq_src_of = `SRC_PORT2;
      default:          freq_src_of = `SRC_LOCAL;
    endcase
  end
endfunction

function [1:0] run_src_of;
  input [3:0] code;
  begin
    case (code)
      4'h2, 4'h3, 4'h5: run_src_of = `SRC_PORT1;
      4'h6, 4'h7, 4'h8: run_src_of = `SRC_PORT2;
      default:          run_src_of = `SRC_LOCAL;
    endcase
  end
endfunction

reg [1:0] fsrc;
reg [1:0] rsrc;
always @* begin
  fsrc = `SRC_LOCAL;
  rsrc = `SRC_LOCAL;
  if (effective_le) begin
    fsrc = fieldbus_source_select_reg[0] ? `SRC_BUS : freq_src_of(serial_source_select_reg);
    rsrc = fieldbus_source_select_reg[1] ? `SRC_BUS : run_src_of(serial_source_select_reg);
  end
end

// local frequency: multistep wins over the setting codes
wire [FREQ_W-1:0] local_freq = multistep_active_in ? multistep_freq_in :
                               (freq_code_sel_reg ? alt_freq_setting_code_reg : freq_setting_code_reg);
// local run: keypad or terminals; general inputs always come from the terminals locally
wire [GEN_W+1:0] local_run = run_source_code_reg ? {fwd_s, rev_s, gen_s} :
                                                   {kfwd_s, krev_reg[1], gen_s};

reg [FREQ_W-1:0] freq_mux;
reg [GEN_W+1:0]  run_mux;
always @* begin
  case (fsrc)
    `SRC_PORT1: freq_mux = port1_freq_in;
    `SRC_PORT2: freq_mux = port2_freq_in;
    `SRC_BUS:   freq_mux = bus_freq_in;
    default:    freq_mux = local_freq;
  endcase
  // one source only feeds the run group; the others are ignored entirely
  case (rsrc)
    `SRC_PORT1: run_mux = port1_run_in;
    `SRC_PORT2: run_mux = port2_run_in;
    `SRC_BUS:   run_mux = bus_run_in;
    default:    run_mux = local_run;
  endcase
end

// registered outputs so a setting change switches cleanly on one edge
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    freq_cmd_out    <= {FREQ_W{1'b0}};
    run_fwd_out     <= 1'b0;
    run_rev_out     <= 1'b0;
    general_cmd_out <= {GEN_W{1'b0}};
    freq_source_out <= `SRC_LOCAL;
    run_source_out  <= `SRC_LOCAL;
  end else begin
    freq_cmd_out    <= freq_mux;
    run_fwd_out     <= run_mux[GEN_W+1];
    run_rev_out     <= run_mux[GEN_W];
    general_cmd_out <= run_mux[GEN_W-1:0];
    freq_source_out <= fsrc;
    run_source_out  <= rsrc;
  end
end

endmodule // command_source_selector
`default_nettype wire

// *** common/cmd_source_consts.vh ***
// constants for the command source selector: register map, field layout, reset values, source codes
`ifndef CMD_SOURCE_CONSTS_VH
`define CMD_SOURCE_CONSTS_VH
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_FREQ_LOCAL  8'h08
`define ADDR_FREQ_PORT1  8'h0C
`define ADDR_FREQ_PORT2  8'h10
`define ADDR_FREQ_BUS    8'h14
`define ADDR_FREQ_SEL    8'h18
`define CTRL_SERIAL_LSB  0
`define CTRL_FIELDBUS_LSB 4
`define CTRL_RUN_CODE_BIT 6
`define CTRL_ALT_FREQ_BIT 7
`define CTRL_LE_ASSIGNED 8
`define CTRL_RESET       32'h0000_0000
`define SERIAL_MAX       4'h8
`define SRC_LOCAL        2'h0
`define SRC_PORT1        2'h1
`define SRC_PORT2        2'h2
`define SRC_BUS          2'h3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// *** bench/command_source_selector_assertions.sv ***
// port checker for the command source selector
`timescale 1ns/100ps
`default_nettype none
`include "cmd_source_consts.vh"
module command_source_selector_assertions #(parameter FREQ_W = 16, parameter GEN_W = 7) (
  input wire logic              clk_in, resetn_in,
  input wire logic              s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out,
  input wire logic              s_axi_bvalid_out, s_axi_bready_in, s_axi_rvalid_out, s_axi_rready_in,
  input wire logic [1:0]        s_axi_bresp_out, freq_source_out, run_source_out,
  input wire logic [31:0]       s_axi_rdata_out,
  input wire logic [FREQ_W-1:0] port1_freq_in, port2_freq_in, bus_freq_in, freq_cmd_out,
  input wire logic [GEN_W+1:0]  port1_run_in, port2_run_in, bus_run_in,
  input wire logic              run_fwd_out, run_rev_out,
  input wire logic [GEN_W-1:0]  general_cmd_out,
  input wire logic [FREQ_W-1:0] multistep_freq_in,
  input wire logic              multistep_active_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire [GEN_W+1:0] run_grp = {run_fwd_out, run_rev_out, general_cmd_out};
  chk_freq_port_one: assert property (freq_source_out == `SRC_PORT1 |-> freq_cmd_out == $past(port1_freq_in))
    else $error("frequency not from port 1");
  chk_freq_port_two: assert property (freq_source_out == `SRC_PORT2 |-> freq_cmd_out == $past(port2_freq_in))
    else $error("frequency not from port 2");
  chk_freq_from_bus: assert property (freq_source_out == `SRC_BUS |-> freq_cmd_out == $past(bus_freq_in))
    else $error("frequency not from fieldbus");
  chk_freq_multistep: assert property (freq_source_out == `SRC_LOCAL && $past(multistep_active_in) |->
    freq_cmd_out == $past(multistep_freq_in)) else $error("local frequency not from multistep");
  chk_run_port_one: assert property (run_source_out == `SRC_PORT1 |-> run_grp == $past(port1_run_in))
    else $error("run group not from port 1");
  chk_run_port_two: assert property (run_source_out == `SRC_PORT2 |-> run_grp == $past(port2_run_in))
    else $error("run group not from port 2");
  chk_run_from_bus: assert property (run_source_out == `SRC_BUS |-> run_grp == $past(bus_run_in))
    else $error("run group not from fieldbus");
  chk_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |=> s_axi_bvalid_out) else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  chk_aw_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out) else $error("write taken while busy");
endmodule // command_source_selector_assertions
`default_nettype wire

// *** bench/remote_link_model.sv ***
// remote controller images on both serial ports and the fieldbus
`timescale 1ns/100ps
`default_nettype none
module remote_link_model (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  output wire logic [15:0] port1_freq_out, port2_freq_out, bus_freq_out,
  output wire logic [8:0]  port1_run_out, port2_run_out, bus_run_out
);
  logic [15:0] cnt_reg;
  // images move every cycle, the fieldbus run image only every 128, so a stale or wrong source cannot pass by luck
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_reg + 16'h0001;
  end
  assign port1_freq_out = cnt_reg;
  assign port2_freq_out = ~cnt_reg;
  assign bus_freq_out = cnt_reg ^ 16'hA5A5;
  assign port1_run_out = cnt_reg[8:0];
  assign port2_run_out = ~cnt_reg[8:0];
  assign bus_run_out = cnt_reg[15:7];
endmodule // remote_link_model
`default_nettype wire

// *** bench/command_source_selector_bench.sv ***
// self-checking bench for the command source selector
`timescale 1ns/100ps
`default_nettype none
`include "cmd_source_consts.vh"
module command_source_selector_bench;
  logic clk_in, resetn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic link_enable_cmd_in, forward_run_input_in, reverse_run_input_in, keypad_run_fwd_in, keypad_run_rev_in;
  logic multistep_active_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, rdv;
  logic [3:0] s_axi_wstrb_in;
  logic [6:0] general_input_in;
  logic [15:0] multistep_freq_in;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire run_fwd_out, run_rev_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out, freq_source_out, run_source_out;
  wire [31:0] s_axi_rdata_out;
  wire [15:0] port1_freq_in, port2_freq_in, bus_freq_in, freq_cmd_out;
  wire [8:0] port1_run_in, port2_run_in, bus_run_in;
  wire [6:0] general_cmd_out;
  logic [1:0] rsp;
  int fails, samples_checked;
  command_source_selector dut (.clk_in, .resetn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .link_enable_cmd_in, .forward_run_input_in, .reverse_run_input_in,
    .general_input_in, .keypad_run_fwd_in, .keypad_run_rev_in, .port1_freq_in, .port1_run_in, .port2_freq_in,
    .port2_run_in, .bus_freq_in, .bus_run_in, .multistep_freq_in, .multistep_active_in, .freq_cmd_out,
    .run_fwd_out, .run_rev_out, .general_cmd_out, .freq_source_out, .run_source_out);
  remote_link_model far (.clk_in, .resetn_in, .port1_freq_out(port1_freq_in), .port2_freq_out(port2_freq_in),
    .bus_freq_out(bus_freq_in), .port1_run_out(port1_run_in), .port2_run_out(port2_run_in), .bus_run_out(bus_run_in));
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    rdv = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task t_srcs(input logic [31:0] ctrl, input logic [1:0] f, input logic [1:0] r);
    wr(`ADDR_CTRL, ctrl);
    settle(1);
    chk("freq_source", f, freq_source_out);
    chk("run_source", r, run_source_out);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`ADDR_CTRL);
    chk("ctrl_reset", `CTRL_RESET, rdv);
    rd(`ADDR_FREQ_PORT2);
    chk("unmapped_rresp", `RESP_SLVERR, rsp);
    wr(`ADDR_FREQ_BUS, 32'h0000_0001);
    chk("unmapped_bresp", `RESP_SLVERR, rsp);
  endtask
  task t_serial;
    for (int s = 0; s <= 8; s++) begin
      // link enable pin stays low and unassigned, so the settings must still apply
      case (s)
        1, 3, 7: t_srcs(s, `SRC_PORT1, (s == 3) ? `SRC_PORT1 : (s == 7) ? `SRC_PORT2 : `SRC_LOCAL);
        4, 5, 8: t_srcs(s, `SRC_PORT2, (s == 5) ? `SRC_PORT1 : (s == 8) ? `SRC_PORT2 : `SRC_LOCAL);
        default: t_srcs(s, `SRC_LOCAL, (s == 2) ? `SRC_PORT1 : (s == 6) ? `SRC_PORT2 : `SRC_LOCAL);
      endcase
    end
    t_srcs(32'h0000_0009, `SRC_PORT2, `SRC_PORT2);
  endtask
  task t_fieldbus;
    for (int f = 0; f < 4; f++)
      t_srcs((f << 4) | 5, f[0] ? `SRC_BUS : `SRC_PORT2, f[1] ? `SRC_BUS : `SRC_PORT1);
  endtask
  task t_link;
    t_srcs(32'h0000_0133, `SRC_LOCAL, `SRC_LOCAL);
    link_enable_cmd_in <= 1'b1;
    settle(4);
    chk("le_on_freq", `SRC_BUS, freq_source_out);
    chk("le_on_run", `SRC_BUS, run_source_out);
    link_enable_cmd_in <= 1'b0;
    settle(4);
    chk("le_off_freq", `SRC_LOCAL, freq_source_out);
    chk("le_off_run", `SRC_LOCAL, run_source_out);
  endtask
  task t_local;
    wr(`ADDR_FREQ_LOCAL, 32'h0000_1234);
    t_srcs(32'h0000_0042, `SRC_LOCAL, `SRC_PORT1);
    forward_run_input_in <= 1'b1;
    general_input_in <= 7'h55;
    wr(`ADDR_CTRL, 32'h0000_0040);
    settle(4);
    chk("local_freq", 32'h0000_1234, freq_cmd_out);
    chk("local_fwd", 1'b1, run_fwd_out);
    chk("local_general", 7'h55, general_cmd_out);
    multistep_freq_in <= 16'hBEEF;
    multistep_active_in <= 1'b1;
    settle(2);
    chk("multistep_freq", 16'hBEEF, freq_cmd_out);
  endtask
  task t_keypad;
    multistep_active_in <= 1'b0;
    keypad_run_rev_in <= 1'b1;
    wr(`ADDR_FREQ_SEL, 32'h0000_5678);
    wr(`ADDR_CTRL, 32'h0000_0080);
    settle(4);
    chk("alt_freq", 32'h0000_5678, freq_cmd_out);
    chk("keypad_rev", 1'b1, run_rev_out);
    chk("terminal_fwd_ignored", 1'b0, run_fwd_out);
    rd(`ADDR_STATUS);
    chk("status", 32'h0000_0010, rdv);
    rd(`ADDR_FREQ_PORT1);
    chk("freq_readback", 32'h0000_5678, rdv);
    s_axi_wstrb_in <= 4'h1;
    wr(`ADDR_FREQ_LOCAL, 32'h0000_00FF);
    s_axi_wstrb_in <= 4'hF;
    rd(`ADDR_FREQ_LOCAL);
    chk("byte_lane_write", 32'h0000_12FF, rdv);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    {resetn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 6'h00;
    {link_enable_cmd_in, forward_run_input_in, reverse_run_input_in, keypad_run_fwd_in, keypad_run_rev_in} = 5'h00;
    {multistep_active_in, multistep_freq_in, general_input_in} = 24'h000000;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    s_axi_wstrb_in = 4'hF;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs;
    t_serial;
    t_fieldbus;
    t_link;
    t_local;
    t_keypad;
    finish_test;
  end
  // the whole sequence needs only about a hundred cycles
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule // command_source_selector_bench
bind command_source_selector command_source_selector_assertions #(.FREQ_W(FREQ_W), .GEN_W(GEN_W)) chk_i (
  .clk_in, .resetn_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_bresp_out,
  .freq_source_out, .run_source_out, .s_axi_rdata_out, .port1_freq_in, .port2_freq_in, .bus_freq_in,
  .freq_cmd_out, .port1_run_in, .port2_run_in, .bus_run_in, .run_fwd_out, .run_rev_out, .general_cmd_out,
  .multistep_freq_in, .multistep_active_in);
`default_nettype wire
